// ==== ssq_peer_unit.sv ====
/*
 * Model of another detector unit sharing the interconnect line.
 * Assumes the bench resolves the wired line, with a pull-down.
 */
`timescale 1ns/100ps
module ssq_peer_unit
	import ssq_pkg::*;
#(
	parameter int DLY_P = 3
) (
	input wire logic clk_in,
	input wire logic smoke_in,
	output logic drive_out
);
	logic [7:0] wait_r;

	// A slow unit raises the line only after DLY_P clocks of smoke.
	always_ff @(posedge clk_in) begin
		wait_r <= smoke_in ? wait_r + {7'h00, wait_r != 8'hff} : 8'h00;
	end
	assign drive_out = smoke_in && (wait_r >= 8'(DLY_P));
endmodule : ssq_peer_unit

// ==== ssq_pkg.sv ====
/*
 * Constants, types and carriers for the smoke alarm sequencer.
 * Assumes a 100 MHz system clock from which the slow oscillator is built.
 */
package ssq_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock and oscillator.
	localparam int CLK_MHZ = 100;
	localparam int OSC_LOW_US = 10400;
	localparam int OSC_HIGH_US = 105;
	localparam int OSC_LOW_CYC = OSC_LOW_US * CLK_MHZ;
	localparam int OSC_HIGH_CYC = OSC_HIGH_US * CLK_MHZ;
	localparam int OSC_PER_US = OSC_LOW_US + OSC_HIGH_US;

	localparam int CW = 12;
	typedef logic [CW-1:0] ssq_cnt_type;

	// Converts a nominal time to whole oscillator cycles, at least one.
	function automatic ssq_cnt_type ssq_ms2cyc(input int ms);
		int c;
		c = ms * 1000 / OSC_PER_US;
		return ssq_cnt_type'((c < 1) ? 1 : c);
	endfunction : ssq_ms2cyc

	////////////////////////////////////////////////////////////////////////
	// Periods in oscillator cycles.
	localparam int CHMB_MS = 43000;
	localparam int LED_FAST_MS = 670;
	localparam int LED_HUSH_MS = 10000;
	localparam int SMP_STBY_MS = 10000;
	localparam int SMP_ONE_MS = 2700;
	localparam int SMP_TWO_MS = 1340;
	localparam int SMP_TEST_MS = 336;
	localparam int HORN_ON_MS = 252;
	localparam int HORN_OFF_MS = 84;
	localparam int HUSH_MS = 600000;
	localparam int HUSH_CYC = HUSH_MS * 1000 / OSC_PER_US;

	localparam ssq_cnt_type CHMB_CYC = ssq_ms2cyc(CHMB_MS);
	localparam ssq_cnt_type LED_FAST_CYC = ssq_ms2cyc(LED_FAST_MS);
	localparam ssq_cnt_type LED_HUSH_CYC = ssq_ms2cyc(LED_HUSH_MS);
	localparam ssq_cnt_type SMP_STBY_CYC = ssq_ms2cyc(SMP_STBY_MS);
	localparam ssq_cnt_type SMP_ONE_CYC = ssq_ms2cyc(SMP_ONE_MS);
	localparam ssq_cnt_type SMP_TWO_CYC = ssq_ms2cyc(SMP_TWO_MS);
	localparam ssq_cnt_type SMP_TEST_CYC = ssq_ms2cyc(SMP_TEST_MS);
	localparam ssq_cnt_type HORN_ON_CYC = ssq_ms2cyc(HORN_ON_MS);
	localparam ssq_cnt_type HORN_PER_CYC =
		ssq_cnt_type'(HORN_ON_CYC + ssq_ms2cyc(HORN_OFF_MS));

	// Slots within the 43 s supervision period.
	localparam ssq_cnt_type LED_STBY_OFS = 12'h000;
	localparam ssq_cnt_type BATT_CHIRP_OFS = 12'h000;
	localparam ssq_cnt_type BATT_TEST_OFS = 12'h002;
	localparam ssq_cnt_type CHMB_TEST_OFS = ssq_cnt_type'(CHMB_CYC / 2 - 2);
	localparam ssq_cnt_type CHMB_CHIRP_OFS = ssq_cnt_type'(CHMB_CYC / 2);

	////////////////////////////////////////////////////////////////////////
	// Small counts.
	localparam logic [1:0] IO_SMP_LAST = 2'h3;
	localparam logic [1:0] IO_QUAL_N = 2'h3;
	localparam logic [1:0] DET_N = 2'h3;
	localparam logic [1:0] CHMB_FAIL_N = 2'h2;
	localparam logic [1:0] EXIT_PULSES = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// Types.
	typedef enum logic [2:0] {
		TST_IDLE,
		TST_ARM,
		TST_RUN,
		TST_REL,
		TST_EXIT
	} ssq_tst_type;

	typedef struct packed {
		logic io;
		logic button;
		logic quiet_en;
	} ssq_in_type;

	typedef struct packed {
		logic local_alarm;
		logic remote_alarm;
		logic test_active;
		logic test_pass;
		logic hush_active;
		logic chamber_fault;
		logic batt_low;
	} ssq_status_type;

endpackage : ssq_pkg

// ==== ssq_seq_monitor.sv ====
/*
 * Port checker for the smoke alarm sequencer, bound to ssq_sequencer.
 * Assumes the emitter high phase is three clocks long.
 */
`timescale 1ns/100ps
module ssq_seq_monitor
	import ssq_pkg::*;
#(
	parameter int LOW_CYC_P = 20,
	parameter int HIGH_CYC_P = 3,
	parameter int HUSH_CYC_P = 200
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic io_in,
	input wire logic button_in,
	input wire logic quiet_en_in,
	input wire logic emitter_out,
	input wire logic io_out,
	input wire logic io_oe_out,
	input wire logic led_out,
	input wire logic sounder_drive_a_out,
	input wire logic sounder_drive_b_out,
	input wire logic high_gain_cap_out,
	input wire logic low_gain_cap_out,
	input wire logic gain_boost_out,
	input wire logic ext_ref_sel_out,
	input wire logic batt_test_out,
	input wire ssq_status_type status_out
);
	localparam int OSC = LOW_CYC_P + HIGH_CYC_P;
	int io_hi_r;
	int btn_r;
	int snd_r;

	always_ff @(posedge clk_in) begin
		io_hi_r <= io_in ? io_hi_r + 1 : 0;
		btn_r <= button_in ? btn_r + 1 : 0;
		snd_r <= sounder_drive_a_out ? snd_r + 1 : 0;
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	////////////////////////////////////////
	sequence s_emit_tail;
		emitter_out[*2] ##1 !emitter_out;
	endsequence
	sequence s_quiet_low;
		(!quiet_en_in)[*5];
	endsequence

	property p_emit_quiet;
		emitter_out |-> !led_out && !sounder_drive_a_out;
	endproperty
	a_emit_quiet: assert property (p_emit_quiet)
		else $error("emitter fired with horn or lamp on");
	property p_emit_width;
		$rose(emitter_out) |=> s_emit_tail;
	endproperty
	a_emit_width: assert property (p_emit_width)
		else $error("emitter pulse width wrong");
	property p_horn_pair;
		sounder_drive_a_out == sounder_drive_b_out;
	endproperty
	a_horn_pair: assert property (p_horn_pair)
		else $error("sounder outputs differ");
	property p_horn_on;
		snd_r <= 23 * OSC;
	endproperty
	a_horn_on: assert property (p_horn_on)
		else $error("sounder on too long");
	property p_gain_excl;
		$past(rst_n_in) |-> high_gain_cap_out != low_gain_cap_out;
	endproperty
	a_gain_excl: assert property (p_gain_excl)
		else $error("gain selects not exclusive");
	property p_boost;
		gain_boost_out |-> status_out.local_alarm && !high_gain_cap_out;
	endproperty
	a_boost: assert property (p_boost)
		else $error("gain boost outside local alarm");
	property p_remote_led;
		status_out.remote_alarm && !status_out.local_alarm
			&& !status_out.test_pass |-> !led_out;
	endproperty
	a_remote_led: assert property (p_remote_led)
		else $error("lamp pulsed during remote alarm");
	property p_hush_ref;
		ext_ref_sel_out == status_out.hush_active;
	endproperty
	a_hush_ref: assert property (p_hush_ref)
		else $error("reference select disagrees with hush");
	property p_hush_gate;
		s_quiet_low |-> !$rose(status_out.hush_active);
	endproperty
	a_hush_gate: assert property (p_hush_gate)
		else $error("hush entered while disabled");
	property p_remote_qual;
		$rose(status_out.remote_alarm) |-> io_hi_r >= 8 * OSC;
	endproperty
	a_remote_qual: assert property (p_remote_qual)
		else $error("remote alarm without qualified line");
	property p_local_drive;
		status_out.local_alarm |-> io_oe_out && io_out;
	endproperty
	a_local_drive: assert property (p_local_drive)
		else $error("local alarm not driving the line");
	property p_test_gain;
		btn_r == 2 * OSC + 4 |-> high_gain_cap_out;
	endproperty
	a_test_gain: assert property (p_test_gain)
		else $error("no high gain while button held");
	property p_batt_alone;
		batt_test_out |-> !emitter_out && !led_out && !sounder_drive_a_out
			&& !status_out.local_alarm && !status_out.remote_alarm
			&& !status_out.test_active;
	endproperty
	a_batt_alone: assert property (p_batt_alone)
		else $error("battery test overlaps another activity");
endmodule : ssq_seq_monitor

bind ssq_sequencer ssq_seq_monitor #(.LOW_CYC_P(LOW_CYC_P),
	.HIGH_CYC_P(HIGH_CYC_P), .HUSH_CYC_P(HUSH_CYC_P)) u_mon (.*);

// ==== ssq_sequencer.sv ====
/*
 * Smoke alarm sequencer: oscillator, emitter timing, gain selection,
 * indicator, sounder pattern, interconnect filter, hush and push-to-test.
 * Assumes inputs are synchronous levels; the interconnect pin resolves
 * its wire level outside from io_out and io_oe_out.
 */
`timescale 1ns/100ps

// Behaviour
// - Sample interconnect every fourth oscillator cycle when no local alarm or test pass.
// - Remote alarm after three high samples plus one more high cycle.
// - Interconnect low at any moment clears the pending qualification.
// - Local smoke drives interconnect high; qualified high sounds horn.
// - Indicator stays off during a remote alarm.
// - Interconnect input ignored during any local alarm.
// - Emitter never fires while horn or indicator is active.
// - Three consecutive detections give local alarm with boosted low gain.
// - High gain in push-to-test and chamber test; low gain in standby.
// - Battery test never coincides with another test or alarm signal.
// - Indicator 43 s standby, 0.67 s smoke or test pass, 10 s hush.
// - Clock low about 10.4 ms; emitter lasts one clock high phase.
// - Button falling edge restarts ten-minute hush when enabled.
// - Hush never entered when quiet enable is low.
// - Hush selects external comparator reference, otherwise internal.
// - Button high: after one cycle switch to high gain.
// - Push-to-test emitter pulses every 336 ms.
// - Test passes on third consecutive simulated detection.
// - On release normal gain after one cycle, exit after three pulses.
// - Alarm horn pattern 252 ms on, 84 ms off.
// - Local beats remote; alarms suppress warning chirps.
// - Two failed chamber tests give one chirp per period until pass.
module ssq_sequencer
	import ssq_pkg::*;
#(
	parameter int LOW_CYC_P = OSC_LOW_CYC,
	parameter int HIGH_CYC_P = OSC_HIGH_CYC,
	parameter int HUSH_CYC_P = HUSH_CYC
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic io_in,
	input wire logic button_in,
	input wire logic quiet_en_in,
	input wire logic smoke_det_in,
	input wire logic low_batt_in,
	output logic emitter_out,
	output logic io_out,
	output logic io_oe_out,
	output logic led_out,
	output logic sounder_drive_a_out,
	output logic sounder_drive_b_out,
	output logic high_gain_cap_out,
	output logic low_gain_cap_out,
	output logic gain_boost_out,
	output logic ext_ref_sel_out,
	output logic batt_test_out,
	output ssq_status_type status_out
);

	localparam int OW = $clog2(LOW_CYC_P + HIGH_CYC_P);

	if (LOW_CYC_P < 2 || HIGH_CYC_P < 1 || HUSH_CYC_P < 1 ||
		HUSH_CYC_P > 65535) begin : g_chk
		$error("ssq_sequencer: unsupported timing parameters");
	end

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers and oscillator.
	ssq_in_type meta_r, sync_r;
	logic btn_r;
	logic [OW-1:0] osc_cnt_r;
	wire tick = osc_cnt_r == OW'(LOW_CYC_P + HIGH_CYC_P - 1);
	wire [OW-1:0] osc_cnt_nxt = tick ? '0 : osc_cnt_r + 1'b1;
	wire hi_nxt = osc_cnt_nxt >= OW'(LOW_CYC_P);
	wire io_s = sync_r.io;
	wire btn_s = sync_r.button;
	wire qen_s = sync_r.quiet_en;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			meta_r <= '0;
			sync_r <= '0;
			osc_cnt_r <= '0;
			btn_r <= 1'b0;
		end else begin
			meta_r <= {io_in, button_in, quiet_en_in};
			sync_r <= meta_r;
			osc_cnt_r <= osc_cnt_nxt;
			if (tick) begin
				btn_r <= btn_s;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State.
	ssq_tst_type tst_r, tst_nxt;
	ssq_cnt_type mcnt_r, smp_cnt_r, led_cnt_r, hpat_r;
	logic [1:0] det_cnt_r, tdet_cnt_r, fail_cnt_r, exit_cnt_r;
	logic [1:0] io_ph_r, io_q_r;
	logic [15:0] hush_cnt_r;
	logic local_r, remote_r, pass_r, fault_r, blow_r;
	logic fire_r, chmb_r, batt_r, horn_r, led_r, hg_r;

	////////////////////////////////////////////////////////////////////////
	// Results of the cycle now ending.
	wire test_on = tst_r != TST_IDLE;
	wire smp_done = tick & fire_r & ~chmb_r;
	wire chmb_done = tick & fire_r & chmb_r;
	wire det_hit = smp_done & ~test_on & (local_r ? ~smoke_det_in :
		smoke_det_in);
	wire det_full = det_hit & (det_cnt_r == DET_N - 2'h1);
	wire [1:0] det_cnt_nxt = (!smp_done || test_on) ? det_cnt_r :
		(!det_hit || det_full) ? 2'h0 : det_cnt_r + 2'h1;
	wire local_nxt = det_full ? ~local_r : local_r;

	// A unit that is driving the line itself does not listen to it.
	wire io_ign = local_r | pass_r;
	wire io_smp = tick & (io_ph_r == IO_SMP_LAST);
	wire [1:0] io_q_nxt = (io_ign || !io_s) ? 2'h0 :
		(io_smp && io_q_r != IO_QUAL_N) ? io_q_r + 2'h1 : io_q_r;
	wire remote_nxt = io_ign ? 1'b0 :
		(tick && io_q_r == IO_QUAL_N && io_s) ? 1'b1 :
		(io_smp && !io_s) ? 1'b0 : remote_r;

	wire test_start = tick & ~test_on & btn_s;
	wire exit_done = smp_done & (tst_r == TST_EXIT) &
		(exit_cnt_r == EXIT_PULSES - 2'h1);

	always_comb begin
		tst_nxt = tst_r;
		if (tick) begin
			case (tst_r)
				TST_IDLE: tst_nxt = btn_s ? TST_ARM : TST_IDLE;
				TST_ARM: tst_nxt = TST_RUN;
				TST_RUN: tst_nxt = btn_s ? TST_RUN : TST_REL;
				TST_REL: tst_nxt = btn_s ? TST_RUN : TST_EXIT;
				TST_EXIT: begin
					if (btn_s) begin
						tst_nxt = TST_ARM;
					end else if (exit_done) begin
						tst_nxt = TST_IDLE;
					end
				end
				default: tst_nxt = TST_IDLE;
			endcase
		end
	end

	wire test_on_nxt = tst_nxt != TST_IDLE;
	wire pass_hit = smp_done & smoke_det_in & (tst_r == TST_RUN) &
		(tdet_cnt_r == DET_N - 2'h1);
	wire pass_nxt = !test_on_nxt ? 1'b0 : pass_hit ? 1'b1 : pass_r;
	wire [1:0] tdet_nxt = !test_on ? 2'h0 : !smp_done ? tdet_cnt_r :
		!smoke_det_in ? 2'h0 :
		(tdet_cnt_r == DET_N) ? DET_N : tdet_cnt_r + 2'h1;

	// Hush is cleared as soon as the enable drops.
	wire hush_start = tick & btn_r & ~btn_s & qen_s;
	wire hush_on = hush_cnt_r != 16'h0000;
	wire [15:0] hush_nxt = !qen_s ? 16'h0000 :
		hush_start ? 16'(HUSH_CYC_P) :
		(tick && hush_on) ? hush_cnt_r - 16'h0001 : hush_cnt_r;

	////////////////////////////////////////////////////////////////////////
	// Schedule of the coming cycle.
	wire alarm_nxt = local_nxt | remote_nxt | pass_nxt;
	wire fast_nxt = local_nxt | pass_nxt;
	wire ssq_cnt_type mcnt_nxt = (mcnt_r == CHMB_CYC - 1'b1) ? '0 :
		mcnt_r + 1'b1;

	wire ssq_cnt_type smp_per = test_on_nxt ? SMP_TEST_CYC :
		(local_nxt || det_cnt_nxt == 2'h2) ? SMP_TWO_CYC :
		(det_cnt_nxt == 2'h1) ? SMP_ONE_CYC : SMP_STBY_CYC;
	wire smp_reload = smp_done | test_start;
	wire ssq_cnt_type smp_cnt_nxt = smp_reload ? smp_per - 1'b1 :
		(tick && smp_cnt_r != '0) ? smp_cnt_r - 1'b1 : smp_cnt_r;

	wire ssq_cnt_type led_per = fast_nxt ? LED_FAST_CYC : LED_HUSH_CYC;
	// A count left from the slow rate is cut short, so the fast blink
	// starts within one fast period instead of up to ten seconds late.
	wire ssq_cnt_type led_cnt_nxt = !tick ? led_cnt_r :
		(led_cnt_r == '0 || led_cnt_r >= led_per) ? led_per - 1'b1 :
		led_cnt_r - 1'b1;
	wire led_on_nxt = (remote_nxt && !fast_nxt) ? 1'b0 :
		(fast_nxt || hush_on) ? led_cnt_r == '0 :
		mcnt_nxt == LED_STBY_OFS;

	wire ssq_cnt_type hpat_nxt = !alarm_nxt ? '0 : !tick ? hpat_r :
		(hpat_r == HORN_PER_CYC - 1'b1) ? '0 : hpat_r + 1'b1;
	wire horn_on_nxt = alarm_nxt ? hpat_nxt < HORN_ON_CYC :
		(fault_r && mcnt_nxt == CHMB_CHIRP_OFS) ||
		(blow_r && mcnt_nxt == BATT_CHIRP_OFS);

	wire quiet = ~horn_on_nxt & ~led_on_nxt;
	wire chmb_nxt = quiet & ~alarm_nxt & ~test_on_nxt &
		(mcnt_nxt == CHMB_TEST_OFS);
	wire fire_nxt = quiet & (chmb_nxt | smp_cnt_nxt == '0);
	wire batt_nxt = ~fire_nxt & ~alarm_nxt & ~test_on_nxt & quiet &
		(mcnt_nxt == BATT_TEST_OFS);
	// High gain is held through the release cycle, so normal gain comes
	// back one oscillator cycle after the button is let go.
	wire hg_nxt = chmb_nxt | (tst_nxt == TST_RUN) |
		(tst_nxt == TST_REL);

	////////////////////////////////////////////////////////////////////////
	// Sequencer registers.
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			tst_r <= TST_IDLE;
			local_r <= 1'b0;
			remote_r <= 1'b0;
			pass_r <= 1'b0;
			det_cnt_r <= 2'h0;
			tdet_cnt_r <= 2'h0;
			io_q_r <= 2'h0;
			hush_cnt_r <= 16'h0000;
			smp_cnt_r <= '0;
			led_cnt_r <= '0;
			hpat_r <= '0;
		end else begin
			tst_r <= tst_nxt;
			local_r <= local_nxt;
			remote_r <= remote_nxt;
			pass_r <= pass_nxt;
			det_cnt_r <= det_cnt_nxt;
			tdet_cnt_r <= tdet_nxt;
			io_q_r <= io_q_nxt;
			hush_cnt_r <= hush_nxt;
			smp_cnt_r <= smp_cnt_nxt;
			led_cnt_r <= led_cnt_nxt;
			hpat_r <= hpat_nxt;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			mcnt_r <= '0;
			io_ph_r <= 2'h0;
			exit_cnt_r <= 2'h0;
			fail_cnt_r <= 2'h0;
			fault_r <= 1'b0;
			blow_r <= 1'b0;
		end else if (tick) begin
			mcnt_r <= mcnt_nxt;
			io_ph_r <= io_ph_r + 2'h1;
			if (tst_r != TST_EXIT) begin
				exit_cnt_r <= 2'h0;
			end else if (smp_done) begin
				exit_cnt_r <= exit_cnt_r + 2'h1;
			end
			if (chmb_done && smoke_det_in) begin
				fail_cnt_r <= 2'h0;
				fault_r <= 1'b0;
			end else if (chmb_done) begin
				if (fail_cnt_r != CHMB_FAIL_N) begin
					fail_cnt_r <= fail_cnt_r + 2'h1;
				end
				if (fail_cnt_r == CHMB_FAIL_N - 2'h1) begin
					fault_r <= 1'b1;
				end
			end
			if (batt_r) begin
				blow_r <= low_batt_in;
			end
		end
	end

	// Per-cycle schedule; it only changes at the oscillator cycle boundary.
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			fire_r <= 1'b0;
			chmb_r <= 1'b0;
			batt_r <= 1'b0;
			horn_r <= 1'b0;
			led_r <= 1'b0;
			hg_r <= 1'b0;
		end else if (tick) begin
			fire_r <= fire_nxt;
			chmb_r <= chmb_nxt;
			batt_r <= batt_nxt;
			horn_r <= horn_on_nxt;
			led_r <= led_on_nxt;
			hg_r <= hg_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output flops.
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			emitter_out <= 1'b0;
			io_out <= 1'b0;
			io_oe_out <= 1'b0;
			led_out <= 1'b0;
			sounder_drive_a_out <= 1'b0;
			sounder_drive_b_out <= 1'b0;
			high_gain_cap_out <= 1'b0;
			low_gain_cap_out <= 1'b0;
			gain_boost_out <= 1'b0;
			ext_ref_sel_out <= 1'b0;
			batt_test_out <= 1'b0;
			status_out <= '0;
		end else begin
			emitter_out <= fire_r & hi_nxt;
			io_out <= 1'b1;
			io_oe_out <= local_r | pass_r;
			led_out <= led_r;
			sounder_drive_a_out <= horn_r;
			sounder_drive_b_out <= horn_r;
			high_gain_cap_out <= hg_r;
			low_gain_cap_out <= ~hg_r;
			gain_boost_out <= local_r & ~hg_r;
			ext_ref_sel_out <= hush_on;
			batt_test_out <= batt_r;
			status_out <= {local_r, remote_r, test_on, pass_r, hush_on,
				fault_r, blow_r};
		end
	end

endmodule : ssq_sequencer

// ==== tb.sv ====
/*
 * Self-checking bench for the smoke alarm sequencer and one peer unit.
 * Assumes shortened oscillator and hush parameters.
 */
`timescale 1ns/100ps
module tb
	import ssq_pkg::*;
;
	localparam int OSC = 23;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic button_in = 1'b0;
	logic quiet_en_in = 1'b0;
	logic smoke_det_in = 1'b0;
	logic low_batt_in = 1'b0;
	logic peer_smoke = 1'b0;
	logic pick = 1'b0;
	logic peer_drive;
	logic emitter_out, io_out, io_oe_out, led_out, batt_test_out;
	logic sounder_drive_a_out, sounder_drive_b_out, gain_boost_out;
	logic high_gain_cap_out, low_gain_cap_out, ext_ref_sel_out;
	ssq_status_type status_out;
	// The line has a pull-down: undriven it reads low.
	wire io_in = peer_drive | (io_oe_out & io_out);
	wire mon = pick ? emitter_out : led_out;
	int miscompares = 0;
	int num_checks = 0;
	int i, led_n, horn_n;
	time t0;

	ssq_sequencer #(.LOW_CYC_P(20), .HIGH_CYC_P(3), .HUSH_CYC_P(200))
		uut (.*);
	ssq_peer_unit #(.DLY_P(3)) peer (.clk_in(clk_in),
		.smoke_in(peer_smoke), .drive_out(peer_drive));

	always #5 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		if (led_out === 1'b1) led_n++;
		if (sounder_drive_a_out === 1'b1) horn_n++;
	end

	////////////////////////////////////////
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen %0h exp %0h", $time, seen, exp);
		end
	endtask : chk

	task osc(input int n);
		repeat (n * OSC) @(negedge clk_in);
	endtask : osc

	task rise(input logic p);
		pick = p;
		for (i = 0; i < 40000 && mon !== 1'b0; i++) @(negedge clk_in);
		for (i = 0; i < 40000 && mon !== 1'b1; i++) @(negedge clk_in);
	endtask : rise

	task gap(input logic p, input int n);
		rise(p);
		t0 = $time;
		rise(p);
		chk(16'(($time - t0) / 10), 16'(n * OSC));
	endtask : gap

	task print_verdict;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : print_verdict

	////////////////////////////////////////
	initial begin
		#900000;
		miscompares++;
		print_verdict();
	end

	initial begin
		repeat (20) @(negedge clk_in);
		rst_n_in = 1'b1;
		@(negedge clk_in);
		chk(io_out, 1'b1);
		chk({high_gain_cap_out, low_gain_cap_out}, 2'h1);
		peer_smoke = 1'b1;
		osc(6);
		peer_smoke = 1'b0;
		// A short drop must throw away the samples already taken.
		osc(1);
		chk(status_out.remote_alarm, 1'b0);
		peer_smoke = 1'b1;
		for (i = 0; i < 20 * OSC && !status_out.remote_alarm; i++)
			@(negedge clk_in);
		chk(status_out.remote_alarm, 1'b1);
		chk(16'(i >= 9 * OSC), 16'h1);
		led_n = 0;
		horn_n = 0;
		osc(80);
		chk(16'(led_n), 16'h0);
		chk(16'(horn_n != 0), 16'h1);
		peer_smoke = 1'b0;
		osc(8);
		chk(status_out.remote_alarm, 1'b0);
		// Push-to-test with simulated smoke, hush enabled on release.
		smoke_det_in = 1'b1;
		quiet_en_in = 1'b1;
		button_in = 1'b1;
		osc(1);
		chk(high_gain_cap_out, 1'b0);
		osc(2);
		chk(high_gain_cap_out, 1'b1);
		gap(1'b1, int'(SMP_TEST_CYC));
		for (i = 0; i < 200 * OSC && !status_out.test_pass; i++)
			@(negedge clk_in);
		chk({status_out.test_pass, io_oe_out}, 2'h3);
		gap(1'b0, int'(LED_FAST_CYC));
		smoke_det_in = 1'b0;
		button_in = 1'b0;
		osc(3);
		chk(high_gain_cap_out, 1'b0);
		chk({status_out.hush_active, ext_ref_sel_out}, 2'h3);
		for (i = 0; i < 150 * OSC && status_out.test_active; i++)
			@(negedge clk_in);
		chk(status_out.test_active, 1'b0);
		for (i = 0; i < 220 * OSC && status_out.hush_active; i++)
			@(negedge clk_in);
		chk(ext_ref_sel_out, 1'b0);
		quiet_en_in = 1'b0;
		button_in = 1'b1;
		osc(3);
		button_in = 1'b0;
		osc(3);
		chk(status_out.hush_active, 1'b0);
		for (i = 0; i < 150 * OSC && status_out.test_active; i++)
			@(negedge clk_in);
		// Local smoke, with the peer also raising the line meanwhile.
		smoke_det_in = 1'b1;
		for (i = 0; i < 1500 * OSC && !status_out.local_alarm; i++)
			@(negedge clk_in);
		chk({status_out.local_alarm, gain_boost_out}, 2'h3);
		chk(io_oe_out, 1'b1);
		peer_smoke = 1'b1;
		osc(20);
		chk(status_out.remote_alarm, 1'b0);
		peer_smoke = 1'b0;
		gap(1'b0, int'(LED_FAST_CYC));
		smoke_det_in = 1'b0;
		for (i = 0; i < 600 * OSC && status_out.local_alarm; i++)
			@(negedge clk_in);
		chk(status_out.local_alarm, 1'b0);
		print_verdict();
	end
endmodule : tb
